//--- core/tsmd_pkg.sv
// constants and types for the tdm switch memory map decoder
// Contract
// RL1 - unassigned address gaps end in bus error
// RL2 - input data memory read only, writes error
// RL3 - connection memory 24576 words of 32 bits
// RL4 - route alias, ber enable, counters, group areas
// RL5 - four clock and init registers consecutive
// RL6 - connection memory self clears after power up
// RL7 - 24 group blocks, 0x1000 bytes apart
// RL8 - stream offset depends on group rate
// RL9 - 8 mbps groups error above offset 0x800
// RL10 - stream address is group base plus offset
// RL11 - each timeslot takes four byte addresses
// RL12 - function field selects output behaviour
// RL13 - voice/data bit and input coding law
// RL14 - host writes zero to bits 23..15
// RL15 - source group and stream channel fields
// RL16 - message mode sends low byte, msb first
// RL17 - output coding law same encodings as input
// RL18 - unavailable stream slots never drive outputs
package tsmd_pkg;
  localparam int unsigned ADDR_W = 19;
  localparam int unsigned CM_WORDS = 24576;
  localparam int unsigned CM_IDX_W = 15;
  localparam int unsigned GROUPS = 24;
  localparam logic [18:0] CM_END = 19'h18000;
  localparam logic [18:0] LSB_BASE = 19'h20000;
  localparam logic [18:0] LSB_END = 19'h26000;
  localparam logic [18:0] DM_BASE = 19'h28000;
  localparam logic [18:0] DM_END = 19'h2E000;
  localparam logic [18:0] BER_BASE = 19'h30000;
  localparam logic [18:0] BER_END = 19'h36000;
  localparam logic [18:0] CNT_BASE = 19'h40000;
  localparam logic [18:0] CNT_END = 19'h40180;
  localparam logic [18:0] GRP_BASE = 19'h40200;
  localparam logic [18:0] GRP_END = 19'h40260;
  localparam logic [18:0] ICK_ADDR = 19'h40280;
  localparam logic [18:0] OCK_ADDR = 19'h40284;
  localparam logic [18:0] INIT_ADDR = 19'h40288;
  localparam logic [18:0] PERMIT_ADDR = 19'h4028C;
  localparam logic [31:0] GRP_RESET = 32'h000C000C;
  localparam logic [31:0] ICK_RESET = 32'h000000DB;
  localparam logic [31:0] OCK_RESET = 32'h060D1C3C;
  localparam logic [31:0] INIT_RESET = 32'h00000000;
  localparam logic [31:0] ZERO_WORD = 32'h00000000;
  // output rate code in group register bits 3:2
  localparam int unsigned RATE_LSB = 2;
  localparam logic [1:0] RATE_65 = 2'h3;
  localparam logic [1:0] RATE_32 = 2'h2;
  localparam logic [1:0] RATE_16 = 2'h1;
  localparam logic [1:0] RATE_8 = 2'h0;
  // connection word fields
  localparam int unsigned FN_MSB = 31;
  localparam int unsigned FN_LSB = 29;
  localparam int unsigned VD_BIT = 28;
  localparam int unsigned ICL_MSB = 27;
  localparam int unsigned ICL_LSB = 26;
  localparam int unsigned OCL_MSB = 25;
  localparam int unsigned OCL_LSB = 24;
  localparam int unsigned GP_MSB = 14;
  localparam int unsigned GP_LSB = 10;
  localparam int unsigned STCH_MSB = 9;
  localparam int unsigned MSG_MSB = 7;
  typedef enum logic [2:0] {
    TSMD_OUTPUT_TRISTATE_FN = 3'b000,
    TSMD_FORCE_HIGH_FN = 3'b001,
    TSMD_MESSAGE_FN = 3'b010,
    TSMD_VARIABLE_DELAY_FN = 3'b011,
    TSMD_CONSTANT_DELAY_FN = 3'b100,
    TSMD_PRBS_FN = 3'b101,
    TSMD_TRISTATE_ALT0_FN = 3'b110,
    TSMD_TRISTATE_ALT1_FN = 3'b111
  } tsmd_fn_e;
  typedef enum logic [1:0] {
    TSMD_IDLE = 2'b00,
    TSMD_ACCESS = 2'b01,
    TSMD_DONE = 2'b10
  } tsmd_state_e;
endpackage

//--- core/tsmd_top.sv
// host bus decoder, register bank and connection memory of the tdm switch
`timescale 1ns/1ps
`default_nettype none
module tsmd_top #(
  parameter int unsigned INIT_WORDS = 24576
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic ds_n,
  input wire logic rd_wr_n,
  input wire logic [18:0] addr_i,
  input wire logic [31:0] data_i,
  output logic [31:0] data_o,
  output logic data_oe,
  output logic dta_n,
  output logic bus_error_flag_n,
  output logic wait_n,
  output logic ctl_oe,
  input wire logic [4:0] core_group,
  input wire logic [1:0] core_stream,
  input wire logic [9:0] core_slot,
  output logic [2:0] channel_function,
  output logic voice_data,
  output logic [1:0] input_coding_law,
  output logic [1:0] output_coding_law,
  output logic [4:0] source_group,
  output logic [9:0] source_stream_channel,
  output logic [7:0] message_byte,
  output logic init_busy
);
  logic [31:0] cm_mem [0:tsmd_pkg::CM_WORDS-1];
  logic ber_mem [0:tsmd_pkg::CM_WORDS-1];
  logic [31:0] grp_reg [0:tsmd_pkg::GROUPS-1];
  logic [31:0] ick_reg;
  logic [31:0] ock_reg;
  logic [31:0] permit_reg;
  logic busy_reg;
  logic [14:0] init_cnt_reg;
  tsmd_pkg::tsmd_state_e state_reg;
  logic [31:0] cm_rd_reg;
  logic ber_rd_reg;
  logic [31:0] data_o_reg;
  logic data_oe_reg;
  logic dta_n_reg;
  logic bus_error_flag_n_reg;
  logic wait_n_reg;
  logic ctl_oe_reg;
  logic [31:0] core_word_reg;
  logic core_valid_reg;

  // address decode
  wire [18:0] a = addr_i;
  wire in_cm = a < tsmd_pkg::CM_END;
  wire in_lsb = (a >= tsmd_pkg::LSB_BASE) && (a < tsmd_pkg::LSB_END);
  wire in_dm = (a >= tsmd_pkg::DM_BASE) && (a < tsmd_pkg::DM_END);
  wire in_ber = (a >= tsmd_pkg::BER_BASE) && (a < tsmd_pkg::BER_END);
  wire in_cnt = (a >= tsmd_pkg::CNT_BASE) && (a < tsmd_pkg::CNT_END);
  wire in_grp = (a >= tsmd_pkg::GRP_BASE) && (a < tsmd_pkg::GRP_END);
  wire [18:0] a_word = {a[18:2], 2'b00};
  wire in_ick = a_word == tsmd_pkg::ICK_ADDR;
  wire in_ock = a_word == tsmd_pkg::OCK_ADDR;
  wire in_init = a_word == tsmd_pkg::INIT_ADDR;
  wire in_permit = a_word == tsmd_pkg::PERMIT_ADDR;
  wire mapped = in_cm | in_lsb | in_dm | in_ber | in_cnt | in_grp | in_ick | in_ock
    | in_init | in_permit; // RL4 RL5
  wire host_wr = ~rd_wr_n;
  // group block g at g*0x1000, timeslot word at offset slot*4; alias area block at g*0x400, slot byte at offset slot
  wire [4:0] host_grp = in_cm ? a[16:12] : a[14:10]; // RL7
  wire [14:0] host_idx = in_cm ? {a[16:12], a[11:2]} : {a[14:10], a[9:0]}; // RL10 RL11
  wire [4:0] reg_idx = a[6:2];
  wire [1:0] host_rate = (host_grp < 5'(tsmd_pkg::GROUPS)) ?
    grp_reg[host_grp][tsmd_pkg::RATE_LSB+:2] : tsmd_pkg::RATE_65;
  wire slow_gap = (host_rate == tsmd_pkg::RATE_8) &&
    ((in_cm && a[11]) || (in_lsb && a[9])); // RL9
  wire host_bus_error_flag = ~mapped | (in_dm & host_wr) | slow_gap; // RL1 RL2
  wire req = ~cs_n & ~ds_n;
  wire start = req && (state_reg == tsmd_pkg::TSMD_IDLE) && ~busy_reg;
  wire acc = state_reg == tsmd_pkg::TSMD_ACCESS;
  wire wr_ok = acc & host_wr & ~host_bus_error_flag;
  wire cm_wr = wr_ok & (in_cm | in_lsb);
  wire [31:0] cm_wdata = in_lsb ? {cm_rd_reg[31:8], data_i[7:0]} : data_i;

  // read data selection
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = tsmd_pkg::ZERO_WORD;
    if (in_cm)
      rd_mux = cm_rd_reg;
    else if (in_lsb)
      rd_mux = {24'h000000, cm_rd_reg[tsmd_pkg::MSG_MSB:0]};
    else if (in_ber)
      rd_mux = {31'h00000000, ber_rd_reg};
    else if (in_grp)
      rd_mux = grp_reg[reg_idx];
    else if (in_ick)
      rd_mux = ick_reg;
    else if (in_ock)
      rd_mux = ock_reg;
    else if (in_init)
      rd_mux = {31'h00000000, busy_reg};
    else if (in_permit)
      rd_mux = permit_reg;
  end

  // memories: init sweep clears words, host writes only when idle of init
  always_ff @(posedge clk)
  begin
    if (busy_reg)
      cm_mem[init_cnt_reg] <= tsmd_pkg::ZERO_WORD; // RL6
    else if (cm_wr)
      cm_mem[host_idx] <= cm_wdata; // RL3
    if (wr_ok & in_ber)
      ber_mem[a[14:0]] <= data_i[0];
    cm_rd_reg <= cm_mem[host_idx];
    ber_rd_reg <= ber_mem[a[14:0]];
  end

  // group control registers
  genvar g;
  generate
    for (g = 0; g < tsmd_pkg::GROUPS; g++)
    begin : grp_gen
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
          grp_reg[g] <= tsmd_pkg::GRP_RESET;
        else if (wr_ok && in_grp && (reg_idx == 5'(g)))
          grp_reg[g] <= data_i;
      end
    end
  endgenerate

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ick_reg <= tsmd_pkg::ICK_RESET;
      ock_reg <= tsmd_pkg::OCK_RESET;
      permit_reg <= tsmd_pkg::INIT_RESET;
    end
    else if (wr_ok)
    begin
      if (in_ick)
        ick_reg <= data_i;
      if (in_ock)
        ock_reg <= data_i;
      if (in_permit)
        permit_reg <= data_i;
    end
  end

  // block initialisation sweep
  wire init_last = init_cnt_reg == 15'(INIT_WORDS - 1);
  wire init_go = wr_ok & in_init & data_i[0] & permit_reg[0];
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      busy_reg <= 1'b1; // RL6
      init_cnt_reg <= 15'h0000;
    end
    else if (busy_reg)
    begin
      busy_reg <= ~init_last;
      init_cnt_reg <= init_last ? 15'h0000 : init_cnt_reg + 15'h0001;
    end
    else if (init_go)
    begin
      busy_reg <= 1'b1;
      init_cnt_reg <= 15'h0000;
    end
  end

  // host bus handshake
  tsmd_pkg::tsmd_state_e state_next;
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      tsmd_pkg::TSMD_IDLE:
        if (start)
          state_next = tsmd_pkg::TSMD_ACCESS;
      tsmd_pkg::TSMD_ACCESS:
        state_next = tsmd_pkg::TSMD_DONE;
      tsmd_pkg::TSMD_DONE:
        if (ds_n | cs_n)
          state_next = tsmd_pkg::TSMD_IDLE;
      default:
        state_next = tsmd_pkg::TSMD_IDLE;
    endcase
    if (cs_n)
      state_next = tsmd_pkg::TSMD_IDLE;
  end

  wire ctl_active = ~dta_n_reg | ~bus_error_flag_n_reg | ~wait_n_reg;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= tsmd_pkg::TSMD_IDLE;
      data_o_reg <= tsmd_pkg::ZERO_WORD;
      data_oe_reg <= 1'b0;
      dta_n_reg <= 1'b1;
      bus_error_flag_n_reg <= 1'b1;
      wait_n_reg <= 1'b1;
      ctl_oe_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      ctl_oe_reg <= ~cs_n | ctl_active;
      data_oe_reg <= ~cs_n & rd_wr_n;
      if (cs_n | (state_reg == tsmd_pkg::TSMD_DONE && ds_n))
      begin
        dta_n_reg <= 1'b1;
        bus_error_flag_n_reg <= 1'b1;
        wait_n_reg <= 1'b1;
      end
      else if (acc)
      begin
        data_o_reg <= rd_mux;
        dta_n_reg <= host_bus_error_flag;
        bus_error_flag_n_reg <= ~host_bus_error_flag; // RL1 RL2 RL9
        wait_n_reg <= 1'b1;
      end
      else if (req && state_reg == tsmd_pkg::TSMD_IDLE)
        wait_n_reg <= 1'b0;
    end
  end

  // switch core lookup: rate dependent stream placement inside a group
  wire [1:0] core_rate = (core_group < 5'(tsmd_pkg::GROUPS)) ?
    grp_reg[core_group][tsmd_pkg::RATE_LSB+:2] : tsmd_pkg::RATE_65;
  logic [9:0] core_off;
  logic core_ok;
  always_comb
  begin
    core_off = core_slot;
    core_ok = 1'b0;
    unique case (core_rate)
      tsmd_pkg::RATE_65:
      begin
        core_off = core_slot;
        core_ok = core_stream == 2'h0;
      end
      tsmd_pkg::RATE_32:
      begin
        core_off = {core_stream[0], core_slot[8:0]};
        core_ok = ~core_stream[1] & ~core_slot[9];
      end
      tsmd_pkg::RATE_16:
      begin
        core_off = {core_stream, core_slot[7:0]};
        core_ok = core_slot[9:8] == 2'h0;
      end
      tsmd_pkg::RATE_8:
      begin
        core_off = {1'b0, core_stream, core_slot[6:0]};
        core_ok = core_slot[9:7] == 3'h0;
      end
    endcase
  end // RL8 RL10 RL11

  wire [14:0] core_idx = {core_group, core_off};
  wire core_in = core_ok && (core_group < 5'(tsmd_pkg::GROUPS));
  always_ff @(posedge clk)
  begin
    core_word_reg <= cm_mem[core_idx];
  end

  // decoded connection word fields
  wire [2:0] fn_raw = core_word_reg[tsmd_pkg::FN_MSB:tsmd_pkg::FN_LSB];
  wire fn_tri = ~core_valid_reg || (fn_raw > tsmd_pkg::TSMD_PRBS_FN); // RL12 RL18
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      core_valid_reg <= 1'b0;
      channel_function <= tsmd_pkg::TSMD_OUTPUT_TRISTATE_FN;
      voice_data <= 1'b0;
      input_coding_law <= 2'h0;
      output_coding_law <= 2'h0;
      source_group <= 5'h00;
      source_stream_channel <= 10'h000;
      message_byte <= 8'h00;
    end
    else
    begin
      core_valid_reg <= core_in;
      channel_function <= fn_tri ? tsmd_pkg::TSMD_OUTPUT_TRISTATE_FN : fn_raw; // RL12
      voice_data <= core_word_reg[tsmd_pkg::VD_BIT]; // RL13
      input_coding_law <= core_word_reg[tsmd_pkg::ICL_MSB:tsmd_pkg::ICL_LSB]; // RL13
      output_coding_law <= core_word_reg[tsmd_pkg::OCL_MSB:tsmd_pkg::OCL_LSB]; // RL17
      source_group <= core_word_reg[tsmd_pkg::GP_MSB:tsmd_pkg::GP_LSB]; // RL15
      source_stream_channel <= core_word_reg[tsmd_pkg::STCH_MSB:0]; // RL15
      message_byte <= core_word_reg[tsmd_pkg::MSG_MSB:0]; // RL16
    end
  end

  assign data_o = data_o_reg;
  assign data_oe = data_oe_reg;
  assign dta_n = dta_n_reg;
  assign bus_error_flag_n = bus_error_flag_n_reg;
  assign wait_n = wait_n_reg;
  assign ctl_oe = ctl_oe_reg;
  assign init_busy = busy_reg;
endmodule
`default_nettype wire

//--- tb/tb_tsmd_top.sv
// testbench for the memory map decoder
`timescale 1ns/1ps
`default_nettype none
module tb_tsmd_top;
  localparam int unsigned INIT_N = 64;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] core_group = 5'h0;
  logic [1:0] core_stream = 2'h0;
  logic [9:0] core_slot = 10'h0;
  logic cs_n, ds_n, rd_wr_n, dta_n, bus_error_flag_n, voice_data, init_busy;
  logic [18:0] addr_i;
  logic [31:0] data_i, data_o, rdata;
  logic [2:0] channel_function;
  logic [1:0] input_coding_law, output_coding_law;
  logic [4:0] source_group;
  logic [9:0] source_stream_channel;
  logic [7:0] message_byte;
  int error_cnt = 0;
  int samples_checked = 0;
  tsmd_top #(.INIT_WORDS(INIT_N)) dut (.clk, .rst, .cs_n, .ds_n, .rd_wr_n, .addr_i, .data_i,
    .data_o, .data_oe(), .dta_n, .bus_error_flag_n, .wait_n(), .ctl_oe(), .core_group,
    .core_stream, .core_slot, .channel_function, .voice_data, .input_coding_law,
    .output_coding_law, .source_group, .source_stream_channel, .message_byte, .init_busy);
  tsmd_host host (.clk, .dta_n, .bus_error_flag_n, .data_o, .cs_n, .ds_n, .rd_wr_n, .addr_i,
    .data_i);
  always #50 clk = ~clk;
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("checks=%0d errors=%0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic io(input logic wr, input logic [18:0] a, input logic [31:0] d,
    input logic e_err, input int hold);
    logic err;
    host.acc(wr, a, d, hold, rdata, err);
    cmp({31'h0, err}, {31'h0, e_err});
  endtask
  task automatic rd(input logic [18:0] a, input logic [31:0] e);
    io(1'b0, a, 32'h0, 1'b0, 0);
    cmp(rdata, e);
  endtask
  // core lookup; f keeps only the function field
  task automatic look(input logic [4:0] g, input logic [1:0] s, input logic [9:0] t,
    input logic [31:0] e, input logic f);
    @(posedge clk);
    core_group <= g;
    core_stream <= s;
    core_slot <= t;
    repeat (3) @(posedge clk);
    #1;
    if (f)
      cmp({29'h0, channel_function}, {29'h0, e[31:29]});
    else
    begin
      cmp({channel_function, voice_data, input_coding_law, output_coding_law, 9'h0,
        source_group, source_stream_channel}, e);
      cmp({24'h0, message_byte}, {24'h0, e[7:0]});
    end
  endtask
  task automatic t_init;
    rd(19'h0, 32'h0);
    rd(19'(INIT_N * 4 - 4), 32'h0);
    rd(tsmd_pkg::ICK_ADDR, tsmd_pkg::ICK_RESET);
    rd(tsmd_pkg::OCK_ADDR, tsmd_pkg::OCK_RESET);
    rd(tsmd_pkg::GRP_BASE, tsmd_pkg::GRP_RESET);
  endtask
  task automatic t_map;
    logic [18:0] bad [9] = '{19'h18000, 19'h1FFFF, 19'h26000, 19'h2E000, 19'h36000,
      19'h40180, 19'h40260, 19'h40290, 19'h7FFFF};
    logic [18:0] good [6] = '{19'h20000, 19'h30000, 19'h40000, 19'h4017C, 19'h40288,
      19'h4028C};
    foreach (bad[i]) io(1'b0, bad[i], 32'h0, 1'b1, 0);
    foreach (good[i]) io(1'b0, good[i], 32'h0, 1'b0, 0);
  endtask
  task automatic t_dm;
    io(1'b1, 19'h28000, 32'hFFFFFFFF, 1'b1, 0);
    io(1'b1, 19'h2DFFC, 32'hFFFFFFFF, 1'b1, 2);
    rd(19'h28000, 32'h0);
  endtask
  task automatic t_reinit;
    io(1'b1, 19'h00010, 32'h5A0003C3, 1'b0, 0);
    io(1'b1, tsmd_pkg::INIT_ADDR, 32'h00000001, 1'b0, 0);
    cmp({31'h0, init_busy}, 32'h0);
    rd(19'h00010, 32'h5A0003C3);
    io(1'b1, tsmd_pkg::PERMIT_ADDR, 32'h00000001, 1'b0, 0);
    rd(tsmd_pkg::PERMIT_ADDR, 32'h00000001);
    io(1'b1, tsmd_pkg::INIT_ADDR, 32'h00000001, 1'b0, 0);
    cmp({31'h0, init_busy}, 32'h1);
    for (int n = 0; n < 200 && init_busy !== 1'b0; n++) @(posedge clk);
    rd(tsmd_pkg::INIT_ADDR, 32'h0);
    rd(19'h00010, 32'h0);
  endtask
  task automatic t_word;
    logic [31:0] w;
    logic [31:0] e;
    for (int i = 0; i < 8; i++)
    begin
      w = {i[2:0], i[0], 2'(i % 3), 2'((i + 1) % 3), 9'h0, 5'(i + 3), 10'h3A5 ^ 10'(i)};
      e = (i > 5) ? {3'h0, w[28:0]} : w;
      io(1'b1, 19'h5FE0 + 19'(i * 4), w, 1'b0, i % 2);
      rd(19'h5FE0 + 19'(i * 4), w);
      look(5'h5, 2'h0, 10'(1016 + i), e, 1'b0);
    end
  endtask
  task automatic t_rate;
    io(1'b1, 19'h4025C, 32'h000C0000, 1'b0, 0);
    io(1'b1, 19'h40210, 32'h000C0004, 1'b0, 0);
    io(1'b1, 19'h17800, 32'h0, 1'b1, 0);
    io(1'b0, 19'h17FFC, 32'h0, 1'b1, 0);
    io(1'b1, 19'h177FC, 32'h48001234, 1'b0, 0);
    look(5'h17, 2'h3, 10'h07F, 32'h48001234, 1'b0);
    look(5'h17, 2'h0, 10'h0C8, 32'h0, 1'b1);
    io(1'b1, 19'h047FC, 32'hA4000C01, 1'b0, 0);
    look(5'h4, 2'h1, 10'h0FF, 32'hA4000C01, 1'b0);
  endtask
  initial
  begin
    #500000;
    error_cnt++;
    summarize();
  end
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int n = 0; n < 200 && init_busy !== 1'b0; n++) @(posedge clk);
    cmp({31'h0, init_busy}, 32'h0);
    t_init();
    t_map();
    t_dm();
    t_reinit();
    t_word();
    t_rate();
    summarize();
  end
endmodule
`default_nettype wire

//--- tb/tsmd_chk.sv
// host bus checks for the memory map decoder
`timescale 1ns/1ps
`default_nettype none
module tsmd_chk #(
  parameter int unsigned INIT_WORDS = 24576
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic ds_n,
  input wire logic rd_wr_n,
  input wire logic [18:0] addr_i,
  input wire logic dta_n,
  input wire logic bus_error_flag_n,
  input wire logic wait_n,
  input wire logic ctl_oe,
  input wire logic data_oe,
  input wire logic [2:0] channel_function,
  input wire logic init_busy
);
  logic [31:0] busy_cnt_reg;
  logic [31:0] busy_cnt_next;
  wire logic gap_a = (addr_i >= 19'h18000) && (addr_i < 19'h20000);
  wire logic top_a = addr_i >= 19'h40290;
  wire logic dm_a = (addr_i >= 19'h28000) && (addr_i < 19'h2E000);
  wire logic reg_a = (addr_i >= 19'h40280) && (addr_i < 19'h40290);
  assign busy_cnt_next = init_busy ? busy_cnt_reg + 32'h1 : 32'h0;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      busy_cnt_reg <= 32'h0;
    else
      busy_cnt_reg <= busy_cnt_next;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_take;
    $fell(ds_n) && !cs_n && !init_busy;
  endsequence
  sequence s_err;
    ##[2:3] (!bus_error_flag_n && dta_n);
  endsequence
  sequence s_ack;
    ##[2:3] (!dta_n && bus_error_flag_n);
  endsequence
  chk_gap_error: assert property (s_take ##0 gap_a |-> s_err)
    else $error("gap access not refused");
  chk_top_error: assert property (s_take ##0 top_a |-> s_err)
    else $error("high gap access not refused");
  chk_dm_write: assert property (s_take ##0 (dm_a && !rd_wr_n) |-> s_err)
    else $error("data memory write not refused");
  chk_dm_read: assert property (s_take ##0 (dm_a && rd_wr_n) |-> s_ack)
    else $error("data memory read not acknowledged");
  chk_reg_ack: assert property (s_take ##0 reg_a |-> s_ack)
    else $error("clock or init register not acknowledged");
  chk_no_early: assert property (s_take |-> ##1 (dta_n && bus_error_flag_n))
    else $error("answer came too early");
  chk_ack_hold: assert property ((!dta_n && !ds_n && !cs_n) |=> !dta_n)
    else $error("acknowledge dropped while strobe low");
  chk_wait_pulse: assert property (s_take |-> ##1 (!wait_n && ctl_oe) ##1 wait_n)
    else $error("wait not pulsed for one cycle");
  chk_read_oe: assert property (s_take |-> ##1 (data_oe == rd_wr_n))
    else $error("data enable does not follow direction");
  chk_fn_alias: assert property (channel_function[2:1] != 2'b11)
    else $error("alias function code reached output");
  chk_init_bound: assert property (busy_cnt_reg <= INIT_WORDS + 8)
    else $error("connection memory clear too long");
endmodule
bind tsmd_top tsmd_chk #(.INIT_WORDS(INIT_WORDS)) u_chk (.clk, .rst, .cs_n, .ds_n, .rd_wr_n,
  .addr_i, .dta_n, .bus_error_flag_n, .wait_n, .ctl_oe, .data_oe, .channel_function, .init_busy);
`default_nettype wire

//--- tb/tsmd_host.sv
// host processor model on the asynchronous bus
`timescale 1ns/1ps
`default_nettype none
module tsmd_host (
  input wire logic clk,
  input wire logic dta_n,
  input wire logic bus_error_flag_n,
  input wire logic [31:0] data_o,
  output logic cs_n,
  output logic ds_n,
  output logic rd_wr_n,
  output logic [18:0] addr_i,
  output logic [31:0] data_i
);
  initial
  begin
    cs_n = 1'b1;
    ds_n = 1'b1;
    rd_wr_n = 1'b1;
    addr_i = 19'h0;
    data_i = 32'h0;
  end
  // one access, strobe held hold cycles past the answer
  task automatic acc(input logic wr, input logic [18:0] a, input logic [31:0] d,
    input int hold, output logic [31:0] q, output logic err);
    int n;
    n = 0;
    err = 1'bx;
    q = 32'hX;
    @(posedge clk);
    cs_n <= 1'b0;
    ds_n <= 1'b0;
    rd_wr_n <= ~wr;
    addr_i <= a;
    data_i <= d;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (dta_n && bus_error_flag_n && n < 40);
    if (n < 40)
      err = ~bus_error_flag_n;
    q = data_o;
    repeat (hold) @(posedge clk);
    cs_n <= 1'b1;
    ds_n <= 1'b1;
    rd_wr_n <= wr;
    addr_i <= ~a;
    data_i <= ~d;
    repeat (3) @(posedge clk);
  endtask
endmodule
`default_nettype wire
